/* File: inc/scu_defines.vh */
`ifndef SCU_DEFINES_VH
`define SCU_DEFINES_VH

// Operation codes on the request port
`define OP_WORD 1'b0
`define OP_DOUBLE 1'b1

// Alignment masks of the effective address
`define ALIGN_WORD_MASK 3'h0_3
`define ALIGN_DOUBLE_MASK 3'h0_7

// Displacement width
`define DISP_W 16

// Result values for the source register
`define RESULT_OK 64'h0000_0000_0000_0001
`define RESULT_FAIL 64'h0000_0000_0000_0000

// Cache access types
`define CCA_W 3
`define CCA_CACHED_NONCOH 3'h0_3
`define CCA_CACHED_COH 3'h0_5

// Byte enables of a full doubleword and of its low and high words
`define BE_ALL 8'hff
`define BE_LOW 8'h0f
`define BE_HIGH 8'hf0

// Reset values
`define LINK_RESET 1'b0

// Coarsest monitored block, as log2 of bytes (minimum page)
`define BLOCK_SHIFT_DEF 12
// Instruction window for the linked pair, in bytes
`define PAIR_WINDOW_BYTES 2048

`endif

/* File: src/link_monitor.v */
`timescale 1ns/1ps
`include "scu_defines.vh"

module link_monitor #(
	parameter ADDR_W = 64,
	parameter BLOCK_SHIFT = `BLOCK_SHIFT_DEF
) (
	input wire sys_clk,
	input wire rst_n,
	input wire ll_valid,
	input wire [ADDR_W-1:0] ll_paddr,
	input wire ll_double,
	input wire snoop_valid,
	input wire [ADDR_W-1:0] snoop_paddr,
	input wire kill,
	input wire consume,
	output reg link_flag,
	output reg link_double,
	output reg [ADDR_W-1:0] link_paddr
);

	wire snoop_hit;

	assign snoop_hit = snoop_valid && link_flag &&
		(snoop_paddr[ADDR_W-1:BLOCK_SHIFT] ==
		link_paddr[ADDR_W-1:BLOCK_SHIFT]);

	// A new load-linked wins over any clear in the same cycle
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			link_flag <= `LINK_RESET;
			link_double <= 1'b0;
			link_paddr <= {ADDR_W{1'b0}};
		end else if (ll_valid) begin
			link_flag <= 1'b1;
			link_double <= ll_double;
			link_paddr <= ll_paddr;
		end else if (snoop_hit || kill || consume) begin
			link_flag <= 1'b0;
		end
	end

endmodule // link_monitor

/* File: src/store_conditional_unit.v */
`timescale 1ns/1ps
`include "scu_defines.vh"

module store_conditional_unit #(
	parameter ADDR_W = 64,
	parameter BLOCK_SHIFT = `BLOCK_SHIFT_DEF,
	parameter LOCAL_ACCESS_KILLS = 1
) (
	input wire sys_clk,
	input wire rst_n,
	input wire sc_valid,
	input wire sc_op,
	input wire [ADDR_W-1:0] base_value,
	input wire [`DISP_W-1:0] displacement,
	input wire [63:0] source_value,
	input wire [4:0] source_result_reg,
	input wire cpu_big_byte_order,
	input wire user_byte_order_swap,
	input wire double_enabled,
	input wire watch_hit,
	input wire xlat_done,
	input wire [ADDR_W-1:0] xlat_paddr,
	input wire [`CCA_W-1:0] cache_coherency_attribute,
	input wire xlat_refill,
	input wire xlat_invalid,
	input wire xlat_modified,
	input wire ll_valid,
	input wire ll_double,
	input wire [ADDR_W-1:0] ll_paddr,
	input wire local_access,
	input wire exception_return,
	input wire exception_taken,
	input wire snoop_valid,
	input wire [ADDR_W-1:0] snoop_paddr,
	input wire mem_ack,
	output reg xlat_req,
	output reg [ADDR_W-1:0] xlat_vaddr,
	output reg mem_wr,
	output reg [ADDR_W-1:0] mem_paddr,
	output reg [63:0] mem_wdata,
	output reg [7:0] mem_be,
	output reg [`CCA_W-1:0] mem_cca,
	output reg result_valid,
	output reg [4:0] result_reg,
	output reg [63:0] result_value,
	output reg exc_valid,
	output reg exc_address_error,
	output reg exc_reserved,
	output reg exc_watch,
	output reg exc_refill,
	output reg exc_invalid,
	output reg exc_modified,
	output reg busy
);

	// ***************************************************************
	// States
	// ***************************************************************
	localparam ST_IDLE = 2'b00;
	localparam ST_XLAT = 2'b01;
	localparam ST_MEM = 2'b10;

	reg [1:0] state;
	reg [1:0] next_state;
	reg op_double;
	reg [63:0] data_hold;
	reg [4:0] reg_hold;
	reg order_big;
	reg order_swap;

	wire link_flag;
	wire link_double;
	wire [ADDR_W-1:0] link_paddr;
	wire [ADDR_W-1:0] eff_addr;
	wire misaligned;
	wire kill;
	wire consume;
	wire link_ok;
	wire [2:0] lane_addr;
	wire [2:0] byte_sel;
	wire [2:0] phys_low;

	// ***************************************************************
	// Address and alignment
	// ***************************************************************
	assign eff_addr = base_value + {{(ADDR_W-`DISP_W){displacement[`DISP_W-1]}},
		displacement};
	assign misaligned = sc_op ?
		(|(eff_addr[2:0] & `ALIGN_DOUBLE_MASK)) :
		(|(eff_addr[2:0] & `ALIGN_WORD_MASK));

	// Local accesses optionally break the link
	assign kill = exception_return || exception_taken ||
		(LOCAL_ACCESS_KILLS != 0 && local_access);

	// Each attempt that completes translation without a fault consumes the link
	assign consume = (state == ST_XLAT) && xlat_done;

	link_monitor #(
		.ADDR_W(ADDR_W),
		.BLOCK_SHIFT(BLOCK_SHIFT)
	) u_link (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ll_valid(ll_valid),
		.ll_paddr(ll_paddr),
		.ll_double(ll_double),
		.snoop_valid(snoop_valid),
		.snoop_paddr(snoop_paddr),
		.kill(kill),
		.consume(consume),
		.link_flag(link_flag),
		.link_double(link_double),
		.link_paddr(link_paddr)
	);

	// Snoop and exception in the check cycle still fail the store
	// Pair span is not tracked, either outcome is allowed
	assign link_ok = link_flag && !kill && !(snoop_valid &&
		(snoop_paddr[ADDR_W-1:BLOCK_SHIFT] ==
		link_paddr[ADDR_W-1:BLOCK_SHIFT])) &&
		(cache_coherency_attribute == `CCA_CACHED_NONCOH ||
		cache_coherency_attribute == `CCA_CACHED_COH);

	// ***************************************************************
	// Byte lanes
	// ***************************************************************
	assign phys_low = xlat_paddr[2:0] ^ {order_swap, 2'b00};
	assign lane_addr = xlat_vaddr[2:0];
	assign byte_sel = lane_addr ^ {order_big, 2'b00};

	// ***************************************************************
	// Sequencer
	// ***************************************************************
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (sc_valid && !misaligned &&
					!(sc_op && !double_enabled) && !watch_hit)
					next_state = ST_XLAT;
			end
			ST_XLAT: begin
				if (xlat_refill || xlat_invalid || xlat_modified)
					next_state = ST_IDLE;
				else if (xlat_done)
					next_state = link_ok ? ST_MEM : ST_IDLE;
			end
			ST_MEM: begin
				if (mem_ack)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			op_double <= 1'b0;
			data_hold <= 64'h0000_0000_0000_0000;
			reg_hold <= 5'h0_0;
			order_big <= 1'b0;
			order_swap <= 1'b0;
			xlat_req <= 1'b0;
			xlat_vaddr <= {ADDR_W{1'b0}};
			mem_wr <= 1'b0;
			mem_paddr <= {ADDR_W{1'b0}};
			mem_wdata <= 64'h0000_0000_0000_0000;
			mem_be <= 8'h00;
			mem_cca <= {`CCA_W{1'b0}};
			result_valid <= 1'b0;
			result_reg <= 5'h0_0;
			result_value <= `RESULT_FAIL;
			exc_valid <= 1'b0;
			exc_address_error <= 1'b0;
			exc_reserved <= 1'b0;
			exc_watch <= 1'b0;
			exc_refill <= 1'b0;
			exc_invalid <= 1'b0;
			exc_modified <= 1'b0;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			result_valid <= 1'b0;
			exc_valid <= 1'b0;
			exc_address_error <= 1'b0;
			exc_reserved <= 1'b0;
			exc_watch <= 1'b0;
			exc_refill <= 1'b0;
			exc_invalid <= 1'b0;
			exc_modified <= 1'b0;
			busy <= (next_state != ST_IDLE);
			case (state)
				ST_IDLE: begin
					if (sc_valid) begin
						if (sc_op && !double_enabled) begin
							exc_valid <= 1'b1;
							exc_reserved <= 1'b1;
						end else if (misaligned) begin
							exc_valid <= 1'b1;
							exc_address_error <= 1'b1;
						end else if (watch_hit) begin
							exc_valid <= 1'b1;
							exc_watch <= 1'b1;
						end else begin
							op_double <= sc_op;
							data_hold <= source_value;
							reg_hold <= source_result_reg;
							order_big <= cpu_big_byte_order;
							order_swap <= user_byte_order_swap;
							xlat_req <= 1'b1;
							xlat_vaddr <= eff_addr;
						end
					end
				end
				ST_XLAT: begin
					if (xlat_refill || xlat_invalid || xlat_modified) begin
						xlat_req <= 1'b0;
						exc_valid <= 1'b1;
						exc_refill <= xlat_refill;
						exc_invalid <= xlat_invalid;
						exc_modified <= xlat_modified;
					end else if (xlat_done) begin
						xlat_req <= 1'b0;
						mem_cca <= cache_coherency_attribute;
						if (link_ok) begin
							mem_wr <= 1'b1;
							if (op_double) begin
								mem_paddr <= xlat_paddr;
								mem_wdata <= data_hold;
								mem_be <= `BE_ALL;
							end else begin
								mem_paddr <= {xlat_paddr[ADDR_W-1:3],
									phys_low};
								mem_wdata <= byte_sel[2] ?
									{data_hold[31:0], 32'h0000_0000} :
									{32'h0000_0000, data_hold[31:0]};
								mem_be <= byte_sel[2] ? `BE_HIGH : `BE_LOW;
							end
						end else begin
							result_valid <= 1'b1;
							result_reg <= reg_hold;
							result_value <= `RESULT_FAIL;
						end
					end
				end
				ST_MEM: begin
					if (mem_ack) begin
						mem_wr <= 1'b0;
						result_valid <= 1'b1;
						result_reg <= reg_hold;
						result_value <= `RESULT_OK;
					end
				end
				default: begin
					xlat_req <= 1'b0;
					mem_wr <= 1'b0;
				end
			endcase
		end
	end

endmodule // store_conditional_unit

/* File: sim/scu_asserts.sv */
`timescale 1ns/1ps
module scu_asserts (
	input wire sys_clk,
	input wire rst_n,
	input wire sc_valid,
	input wire sc_op,
	input wire [63:0] base_value,
	input wire [15:0] displacement,
	input wire double_enabled,
	input wire xlat_req,
	input wire [63:0] xlat_vaddr,
	input wire xlat_refill,
	input wire mem_wr,
	input wire mem_ack,
	input wire result_valid,
	input wire [63:0] result_value,
	input wire exc_valid,
	input wire exc_address_error,
	input wire exc_reserved,
	input wire exc_refill,
	input wire busy
);
	wire [63:0] ea = base_value + {{48{displacement[15]}}, displacement};
	wire take = sc_valid && !busy;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	addr_form_a: assert property (
		$rose(xlat_req) |-> xlat_vaddr == $past(ea)) else $error("bad vaddr");
	word_align_a: assert property (
		take && !sc_op && ea[1:0] != 2'h0 |=> exc_valid && exc_address_error)
		else $error("word align");
	double_align_a: assert property (
		take && sc_op && double_enabled && ea[2:0] != 3'h0
		|=> exc_valid && exc_address_error) else $error("double align");
	reserved_op_a: assert property (
		take && sc_op && !double_enabled |=> exc_valid && exc_reserved)
		else $error("no reserved");
	refill_fault_a: assert property (
		xlat_req && xlat_refill |=> exc_valid && exc_refill && !mem_wr)
		else $error("no refill");
	success_one_a: assert property (
		mem_wr && mem_ack |=> result_valid && result_value == 64'h1)
		else $error("no success");
	fail_no_store_a: assert property (
		result_valid && result_value == 64'h0 |-> !$past(mem_wr))
		else $error("store on fail");
	write_hold_a: assert property (
		mem_wr && !mem_ack |=> mem_wr) else $error("write dropped");
endmodule // scu_asserts

bind store_conditional_unit scu_asserts chk (.sys_clk, .rst_n, .sc_valid,
	.sc_op, .base_value, .displacement, .double_enabled, .xlat_req,
	.xlat_vaddr, .xlat_refill, .mem_wr, .mem_ack, .result_valid,
	.result_value, .exc_valid, .exc_address_error, .exc_reserved,
	.exc_refill, .busy);

/* File: sim/mem_side_model.sv */
`timescale 1ns/1ps
`include "scu_defines.vh"
module mem_side_model (
	input wire sys_clk,
	input wire xlat_req,
	input wire [63:0] xlat_vaddr,
	input wire mem_wr,
	input wire [1:0] fault,
	input wire noncoh,
	input wire [1:0] lag,
	output reg xlat_done = 0,
	output reg xlat_refill = 0,
	output reg xlat_invalid = 0,
	output reg xlat_modified = 0,
	output reg [63:0] xlat_paddr = 0,
	output reg [2:0] cca = 0,
	output reg mem_ack = 0
);
	integer n = 0;
	wire answered = xlat_done || xlat_refill || xlat_invalid ||
		xlat_modified || mem_ack;
	always @(posedge sys_clk) begin
		xlat_done <= 0;
		xlat_refill <= 0;
		xlat_invalid <= 0;
		xlat_modified <= 0;
		mem_ack <= 0;
		xlat_paddr <= ~xlat_paddr;
		cca <= ~cca;
		n <= 0;
		if ((xlat_req || mem_wr) && !answered) begin
			n <= n + 1;
			if (n >= lag) begin
				n <= 0;
				mem_ack <= mem_wr;
				xlat_done <= xlat_req && fault == 2'h0;
				xlat_refill <= xlat_req && fault == 2'h1;
				xlat_invalid <= xlat_req && fault == 2'h2;
				xlat_modified <= xlat_req && fault == 2'h3;
				xlat_paddr <= xlat_vaddr;
				cca <= noncoh ? `CCA_CACHED_NONCOH :
					`CCA_CACHED_COH;
			end
		end
	end
endmodule // mem_side_model

/* File: sim/store_conditional_unit_test.sv */
`timescale 1ns/1ps
`include "scu_defines.vh"
module store_conditional_unit_test;
	reg sys_clk = 0, rst_n = 0, sc_valid = 0, sc_op = 0, cpu_big_byte_order = 0;
	reg double_enabled = 1, ll_valid = 0, ll_double = 0, link = 0;
	reg watch_hit = 0, local_access = 0, user_byte_order_swap = 0;
	reg noncoh = 0, hung = 0;
	reg [1:0] fault = 0;
	reg exception_return = 0, exception_taken = 0, snoop_valid = 0;
	reg [63:0] base_value = 0, source_value = 0, ll_paddr = 0, snoop_paddr = 0;
	reg [63:0] laddr = 0, b, a;
	reg [15:0] displacement = 0, d;
	reg [4:0] source_result_reg = 0;
	reg [1:0] lag = 0;
	reg [31:0] rs = 32'h4593_6361;
	integer error_cnt = 0, checks_done = 0, i;
	wire xlat_req, xlat_done, xlat_refill, mem_wr, mem_ack, result_valid, busy;
	wire exc_valid, exc_address_error, exc_reserved, exc_refill;
	wire exc_watch, exc_invalid, exc_modified, xlat_invalid, xlat_modified;
	wire [63:0] xlat_vaddr, xlat_paddr, mem_paddr, mem_wdata, result_value;
	wire [7:0] mem_be;
	wire [4:0] result_reg;
	wire [2:0] cca, mem_cca;

	store_conditional_unit DUT (.sys_clk, .rst_n, .sc_valid, .sc_op,
		.base_value, .displacement, .source_value, .source_result_reg,
		.cpu_big_byte_order, .user_byte_order_swap, .double_enabled,
		.watch_hit, .xlat_done, .xlat_paddr,
		.cache_coherency_attribute(cca), .xlat_refill, .xlat_invalid,
		.xlat_modified, .ll_valid, .ll_double, .ll_paddr,
		.local_access, .exception_return, .exception_taken, .snoop_valid,
		.snoop_paddr, .mem_ack, .xlat_req, .xlat_vaddr, .mem_wr, .mem_paddr,
		.mem_wdata, .mem_be, .mem_cca, .result_valid, .result_reg,
		.result_value, .exc_valid, .exc_address_error, .exc_reserved,
		.exc_watch, .exc_refill, .exc_invalid, .exc_modified, .busy);
	mem_side_model far (.sys_clk, .xlat_req, .xlat_vaddr, .mem_wr, .fault,
		.noncoh, .lag, .xlat_done, .xlat_refill, .xlat_invalid,
		.xlat_modified, .xlat_paddr, .cca, .mem_ack);

	always #20 sys_clk = ~sys_clk;

	function [31:0] xs(input [31:0] x);
		reg [31:0] y;
		begin
			y = x ^ (x << 13);
			y = y ^ (y >> 17);
			xs = y ^ (y << 5);
		end
	endfunction

	task print_verdict;
		begin
			$display("checks %0d errors %0d", checks_done, error_cnt);
			if (error_cnt == 0 && checks_done > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask

	task chk(input [68:0] got, input [68:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("unexpected at %0t: %h vs %h", $time, got, exp);
			end
		end
	endtask

	// ****************
	// Link events
	// ****************
	task ev(input integer k, input [63:0] x);
		begin
			@(posedge sys_clk) #1;
			case (k)
			0: begin
				ll_valid = 1;
				ll_paddr = x;
				ll_double = sc_op;
				link = 1;
				laddr = x;
			end
			1: begin
				snoop_valid = 1;
				snoop_paddr = x;
				if (x[63:12] == laddr[63:12])
					link = 0;
			end
			2: begin
				exception_return = 1;
				link = 0;
			end
			3: begin
				exception_taken = 1;
				link = 0;
			end
			default: begin
				local_access = 1;
				link = 0;
			end
			endcase
			@(posedge sys_clk) #1;
			{ll_valid, snoop_valid, exception_return} = 3'h0;
			{exception_taken, local_access} = 2'h0;
		end
	endtask

	task sc;
		reg [63:0] ea, v;
		reg [6:0] ee;
		reg bs, done;
		integer n;
		begin
			@(posedge sys_clk) #1;
			rs = xs(rs);
			v = {rs, xs(rs)};
			ea = b + {{48{d[15]}}, d};
			bs = ea[2] ^ rs[7];
			ee = sc_op && !double_enabled ? 7'h50 :
				(sc_op ? |ea[2:0] : |ea[1:0]) ? 7'h60 :
				watch_hit ? 7'h48 :
				fault != 2'h0 ? 7'h40 | (7'h08 >> fault) : 7'h00;
			sc_valid = 1;
			base_value = b;
			displacement = d;
			source_value = v;
			source_result_reg = rs[4:0];
			cpu_big_byte_order = rs[7];
			lag = rs[9:8];
			user_byte_order_swap = rs[11];
			@(posedge sys_clk) #1;
			sc_valid = 0;
			done = 0;
			for (n = 0; n < 40 && !done; n = n + 1) begin
				if (n == 0)
					chk(busy, ~|ee[5:3]);
				if (mem_wr === 1'b1) begin
					chk(mem_be, !link ? 0 : sc_op ? 8'hff : bs ? 8'hf0 : 8'h0f);
					chk(sc_op ? mem_wdata : bs ? mem_wdata[63:32] : mem_wdata[31:0],
						sc_op ? v : v[31:0]);
					chk(mem_paddr, sc_op ? ea : ea ^ {rs[11], 2'b00});
					chk(mem_cca, noncoh ? `CCA_CACHED_NONCOH :
						`CCA_CACHED_COH);
				end
				if (exc_valid === 1'b1 || result_valid === 1'b1) begin
					chk({exc_valid, exc_address_error, exc_reserved,
						exc_watch, exc_refill, exc_invalid, exc_modified}, ee);
					chk(busy, 1'b0);
					if (ee == 7'h00)
						chk({result_reg, result_value}, {rs[4:0], 63'h0, link});
					done = 1;
				end else
					@(posedge sys_clk) #1;
			end
			if (!done) begin
				error_cnt = error_cnt + 1;
				hung = 1;
				$display("unexpected at %0t: %h vs %h", $time, done, 1'b1);
			end
			if (ee == 7'h00)
				link = 0;
		end
	endtask

	initial begin
		repeat (3) @(posedge sys_clk);
		#1 rst_n = 1;
		for (i = 0; i < 32 && !hung; i = i + 1) begin
			rs = xs(rs);
			sc_op = i[0];
			noncoh = rs[5];
			b = {rs, rs} & ~64'h7;
			d = {rs[31:19], 3'h0};
			a = b + {{48{d[15]}}, d};
			ev(0, a);
			case (i[3:1])
			1: ev(1, a ^ 64'h8);
			2: ev(1, a ^ 64'h1000);
			3: begin
				ev(2, 0);
				watch_hit = i[4];
			end
			4: ev(3 + i[4], 0);
			5: d = d | 16'h1;
			6: fault = {i[4], 1'b1};
			7: begin
				double_enabled = 0;
				fault = {i[4], 1'b0};
			end
			default: ;
			endcase
			sc;
			if (i[3:1] == 0 && !hung)
				sc;
			fault = 0;
			double_enabled = 1;
			watch_hit = 0;
		end
		print_verdict;
	end
endmodule // store_conditional_unit_test
